// ---- rtl/tmsc_pkg.sv ----
// Package: register offsets, field positions, reset values for the timer
package tmsc_pkg;
    // Register offsets (byte addresses on the plain port)
    localparam logic [3:0] OFF_CONFIG_FIRST = 4'h0;
    localparam logic [3:0] OFF_CONFIG_SECOND = 4'h1;
    localparam logic [3:0] OFF_COUNT_LOW = 4'h2;
    localparam logic [3:0] OFF_COUNT_HIGH = 4'h3;
    localparam logic [3:0] OFF_EVENT_STATUS = 4'h4;
    // First config fields
    localparam int POS_ENABLE = 7;
    localparam int POS_OUT = 5;
    localparam int POS_WIDE = 4;
    localparam int POS_OUTDIV = 0;
    // Second config fields
    localparam int POS_SRC = 5;
    localparam int POS_ASYNC = 4;
    localparam int POS_PRESCALE = 0;
    // Status fields
    localparam int POS_FLAG = 0;
    localparam int POS_IRQ_EN = 1;
    // Reset values
    localparam logic [7:0] RST_CONFIG_FIRST = 8'h00;
    localparam logic [7:0] RST_CONFIG_SECOND = 8'h00;
    localparam logic [7:0] RST_COUNT_LOW = 8'h00;
    localparam logic [7:0] RST_COUNT_HIGH = 8'hFF;
    localparam logic [14:0] RST_PRESCALE_COUNT = 15'h0000;
    localparam logic [3:0] RST_POST_COUNT = 4'h0;
    // Source select codes
    localparam logic [2:0] SRC_EXT_RISE = 3'h0;
    localparam logic [2:0] SRC_SYS = 3'h2;
endpackage

// ---- rtl/tmsc_edge_if.sv ----
// Interface: synchronised clock-source edge strobes into the core
`timescale 1ns/1ps
interface tmsc_edge_if;
    logic tick;
    logic [2:0] srcSel;
    modport producer (input srcSel, output tick);
    modport consumer (output srcSel, input tick);
endinterface

// ---- rtl/tmsc_source_sel.sv ----
// Source selector: synchronises pin clocks and makes one tick per rising edge
`timescale 1ns/1ps
module tmsc_source_sel
    import tmsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] srcPins,
    tmsc_edge_if.producer edge_io
);
    logic [7:0] syncA, syncB, syncC, stable;
    logic [7:0] next_stable;
    logic tick, next_tick;
    logic selNow, selWas;

    // Stable level changes once stages two and three agree
    always_comb begin
        next_stable = stable;
        for (int i = 0; i < 8; i++) begin
            if (syncB[i] == syncC[i]) begin
                next_stable[i] = syncC[i];
            end
        end
        selNow = next_stable[edge_io.srcSel];
        selWas = stable[edge_io.srcSel];
        // Source 2 is the system clock itself: tick every cycle
        if (edge_io.srcSel == SRC_SYS) begin
            next_tick = 1'b1;
        end else begin
            next_tick = selNow & ~selWas;
        end
    end

    // Synchroniser chain and edge detector registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 8'h00;
            syncB <= 8'h00;
            syncC <= 8'h00;
            stable <= 8'h00;
            tick <= 1'b0;
        end else begin
            syncA <= srcPins;
            syncB <= syncA;
            syncC <= syncB;
            stable <= next_stable;
            tick <= next_tick;
        end
    end

    assign edge_io.tick = tick;
endmodule

// ---- rtl/tmsc_postscaler.sv ----
// Postscaler: divides timer events by N+1 and pulses once per group
`timescale 1ns/1ps
module tmsc_postscaler
    import tmsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clearCount,
    input wire logic timerEvent,
    input wire logic [3:0] divSel,
    output logic outPulse
);
    logic [3:0] count, next_count;
    logic next_outPulse;

    // Count events; a write clear overrides and discards partial groups
    always_comb begin
        next_count = count;
        next_outPulse = 1'b0;
        if (clearCount) begin
            next_count = RST_POST_COUNT;
        end else if (timerEvent) begin
            if (count >= divSel) begin
                next_count = RST_POST_COUNT;
                next_outPulse = 1'b1;
            end else begin
                next_count = count + 4'h1;
            end
        end
    end

    // Hidden event count, no software path to it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= RST_POST_COUNT;
            outPulse <= 1'b0;
        end else begin
            count <= next_count;
            outPulse <= next_outPulse;
        end
    end
endmodule

// ---- rtl/tmsc_timer0.sv ----
// Timer/counter top: registers, prescaler, count, flag and output
// What this block does
// - Three-bit field in second config picks the counting clock source.
// - Internal source: count once per prescaled group of clock periods.
// - External source: count once per prescaled group of rising edges.
// - Four-bit prescale field picks divide by 1 up to 32768.
// - Prescaler count cannot be read or loaded by software.
// - Writing low count or second config clears the prescaler.
// - Postscaler divides events by 1 to 16 via first config field.
// - Postscaler count cannot be read or loaded by software.
// - Writing low count or first config clears the postscaler.
// - Synchronous mode halts counting while the device sleeps.
// - Asynchronous mode counts in sleep and wakes device if enabled.
// - Event on 8-bit match with compare byte or 16-bit rollover.
// - Flag sets once every N+1 timer events.
// - Output toggles on each postscaled pulse, giving 50% duty.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module tmsc_timer0
    import tmsc_pkg::*;
#(
    parameter int PRESCALE_BITS = 15
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic [7:0] srcPins,
    input wire logic sleepMode,
    output logic timerOut,
    output logic eventFlag,
    output logic wakeReq
);
    logic [7:0] cfgFirst, next_cfgFirst;
    logic [7:0] cfgSecond, next_cfgSecond;
    logic [7:0] countLow, next_countLow;
    logic [7:0] countHigh, next_countHigh;
    logic [7:0] next_regRdata;
    logic flag, next_flag, irqEn, next_irqEn;
    logic outLvl, next_outLvl, next_wakeReq;
    logic [PRESCALE_BITS-1:0] preCount, next_preCount;
    logic matchPend, next_matchPend;
    logic preTick, advance, timerEvent, postPulse;
    logic wrLow, wrHigh, wrFirst, wrSecond, wrStatus;
    logic enable, wide, asyncMode, halted;
    logic [3:0] prescaleSel;
    logic [15:0] fullCount;

    tmsc_edge_if edge_io ();

    tmsc_source_sel u_src (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .srcPins(srcPins),
        .edge_io(edge_io)
    );

    tmsc_postscaler u_post (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clearCount(wrLow | wrFirst),
        .timerEvent(timerEvent),
        .divSel(cfgFirst[POS_OUTDIV +: 4]),
        .outPulse(postPulse)
    );

    // Address decode for writes
    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        return a == o;
    endfunction

    assign wrLow = regWr && hit(regAddr, OFF_COUNT_LOW);
    assign wrHigh = regWr && hit(regAddr, OFF_COUNT_HIGH);
    assign wrFirst = regWr && hit(regAddr, OFF_CONFIG_FIRST);
    assign wrSecond = regWr && hit(regAddr, OFF_CONFIG_SECOND);
    assign wrStatus = regWr && hit(regAddr, OFF_EVENT_STATUS);

    // Field views
    assign edge_io.srcSel = cfgSecond[POS_SRC +: 3];
    assign enable = cfgFirst[POS_ENABLE];
    assign wide = cfgFirst[POS_WIDE];
    assign asyncMode = cfgSecond[POS_ASYNC];
    assign prescaleSel = cfgSecond[POS_PRESCALE +: 4];
    assign fullCount = {countHigh, countLow};
    // Synchronous mode stops in sleep; async keeps going
    assign halted = sleepMode && !asyncMode;

    // Prescaler: tick when low prescaleSel bits all ones
    always_comb begin
        next_preCount = preCount;
        preTick = 1'b0;
        if (enable && !halted && edge_io.tick) begin
            if (prescaleSel == 4'h0 ||
                &(preCount | ~((PRESCALE_BITS'(1) << prescaleSel)
                    - PRESCALE_BITS'(1)))) begin
                preTick = 1'b1;
                next_preCount = '0;
            end else begin
                next_preCount = preCount + PRESCALE_BITS'(1);
            end
        end
        // Write clear wins; count never visible on the bus
        if (wrLow || wrSecond) begin
            next_preCount = '0;
        end
    end
    assign advance = preTick;

    // Count, match and rollover
    always_comb begin
        next_countLow = countLow;
        next_countHigh = countHigh;
        next_matchPend = matchPend;
        timerEvent = 1'b0;
        if (advance) begin
            if (wide) begin
                {next_countHigh, next_countLow} = fullCount + 16'h0001;
                timerEvent = (fullCount == 16'hFFFF);
            end else if (matchPend) begin
                next_countLow = 8'h00;
                next_matchPend = 1'b0;
            end else begin
                next_countLow = countLow + 8'h01;
                if (next_countLow == countHigh) begin
                    timerEvent = 1'b1;
                    next_matchPend = 1'b1;
                end
            end
        end
        if (!wide && matchPend && countLow != countHigh) begin
            next_matchPend = 1'b0;
        end
        // Software writes override the count; no 16-bit ISR reload path
        if (wrLow) begin
            next_countLow = regWdata;
            next_matchPend = 1'b0;
        end
        if (wrHigh) begin
            next_countHigh = regWdata;
        end
    end

    // Config, flag, output level, wake and read data
    always_comb begin
        next_cfgFirst = cfgFirst;
        next_cfgSecond = cfgSecond;
        next_irqEn = irqEn;
        next_flag = flag;
        next_outLvl = outLvl;
        if (wrFirst) begin
            next_cfgFirst = regWdata;
        end
        if (wrSecond) begin
            next_cfgSecond = regWdata;
        end
        if (wrStatus) begin
            next_irqEn = regWdata[POS_IRQ_EN];
            if (!regWdata[POS_FLAG]) begin
                next_flag = 1'b0;
            end
        end
        // Hardware set beats a same-cycle clear
        if (postPulse) begin
            next_flag = 1'b1;
            next_outLvl = !outLvl;
        end
        next_wakeReq = sleepMode && asyncMode && irqEn && next_flag;
        next_regRdata = 8'h00;
        if (regRd) begin
            if (hit(regAddr, OFF_CONFIG_FIRST)) begin
                next_regRdata = cfgFirst;
                next_regRdata[POS_OUT] = outLvl;
            end else if (hit(regAddr, OFF_CONFIG_SECOND)) begin
                next_regRdata = cfgSecond;
            end else if (hit(regAddr, OFF_COUNT_LOW)) begin
                next_regRdata = countLow;
            end else if (hit(regAddr, OFF_COUNT_HIGH)) begin
                next_regRdata = countHigh;
            end else if (hit(regAddr, OFF_EVENT_STATUS)) begin
                next_regRdata = {6'h00, irqEn, flag};
            end else begin
                next_regRdata = 8'h00;
            end
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgFirst <= RST_CONFIG_FIRST;
            cfgSecond <= RST_CONFIG_SECOND;
            countLow <= RST_COUNT_LOW;
            countHigh <= RST_COUNT_HIGH;
            preCount <= '0;
            matchPend <= 1'b0;
            flag <= 1'b0;
            irqEn <= 1'b0;
            outLvl <= 1'b0;
            regRdata <= 8'h00;
            timerOut <= 1'b0;
            eventFlag <= 1'b0;
            wakeReq <= 1'b0;
        end else begin
            cfgFirst <= next_cfgFirst;
            cfgSecond <= next_cfgSecond;
            countLow <= next_countLow;
            countHigh <= next_countHigh;
            preCount <= next_preCount;
            matchPend <= next_matchPend;
            flag <= next_flag;
            irqEn <= next_irqEn;
            outLvl <= next_outLvl;
            regRdata <= next_regRdata;
            timerOut <= next_outLvl;
            eventFlag <= next_flag;
            wakeReq <= next_wakeReq;
        end
    end

    // Checks: scaler clears and holds
    a_prescale_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrLow || wrSecond) |=> preCount == '0)
        else $error("prescaler not cleared by write");
    a_post_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (wrLow || wrFirst) |=> !postPulse)
        else $error("postscaler pulsed through a clear");
    a_post_div: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (timerEvent && cfgFirst[3:0] == 4'h0 && !wrLow && !wrFirst)
        |=> postPulse)
        else $error("1:1 postscale missed an event");
    // Writes may still move the count while halted
    a_sleep_halts: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (halted && !wrLow && !wrHigh) |=> $stable(fullCount))
        else $error("count moved in synchronous sleep");
    a_idle_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!enable && !wrLow && !wrHigh) |=> $stable(fullCount))
        else $error("count moved while disabled");

    // Checks: count, match and rollover
    a_count_step: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (advance && !wide && !matchPend && !wrLow)
        |=> countLow == $past(countLow) + 8'h01)
        else $error("low byte did not step");
    a_wide_roll: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (advance && wide && fullCount == 16'hFFFF && !wrLow && !wrHigh)
        |-> timerEvent ##1 fullCount == 16'h0000)
        else $error("rollover missed");
    a_match_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (advance && !wide && matchPend && !wrLow) |=> countLow == 8'h00)
        else $error("low byte not cleared after match");

    // Checks: flag, output and wake; flag and outputs share an edge
    a_flag_set: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        postPulse |=> flag && eventFlag)
        else $error("flag not set on postscaled pulse");
    a_flag_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (flag && !wrStatus) |=> flag)
        else $error("flag dropped without a clear");
    a_out_toggle: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        postPulse |=> outLvl != $past(outLvl))
        else $error("output did not toggle");
    a_out_pin: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        postPulse |=> timerOut != $past(timerOut))
        else $error("output pin did not toggle");
    // A same-cycle clear may drop the flag, and the wake goes with it
    a_wake: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (sleepMode && asyncMode && irqEn && flag) |=> wakeReq == flag)
        else $error("no wake while flagged in async sleep");
    a_wake_sync: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (sleepMode && !asyncMode) |=> !wakeReq)
        else $error("wake raised in synchronous sleep");

    // Checks: register read path
    a_read_low: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regRd && regAddr == OFF_COUNT_LOW) |=> regRdata == $past(countLow))
        else $error("low byte read wrong");

    // Scenarios the bench is expected to reach
    c_event: cover property (@(posedge sys_clk) disable iff (!rst_n)
        timerEvent);
    c_pulse: cover property (@(posedge sys_clk) disable iff (!rst_n)
        postPulse);
    c_wake: cover property (@(posedge sys_clk) disable iff (!rst_n) wakeReq);
    c_roll: cover property (@(posedge sys_clk) disable iff (!rst_n)
        advance && wide && fullCount == 16'hFFFF);
    c_sleep_hold: cover property (@(posedge sys_clk) disable iff (!rst_n)
        halted && enable);
endmodule

// ---- sim/tmsc_src_model.sv ----
// Far-side model: external clock on pin 0, busy noise on the other pins
`timescale 1ns/1ps
module tmsc_src_model #(
    parameter int HALF = 4
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    output logic [7:0] srcPins
);
    int phase;
    logic pinClk;
    logic [6:0] noise;

    // Pin clock runs only while run is high, otherwise it stands still
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 0;
            pinClk <= 1'b0;
            noise <= 7'h00;
        end else begin
            noise <= noise + 7'h01; // Unselected pins never rest
            if (run) begin
                phase <= (phase == HALF - 1) ? 0 : phase + 1;
                if (phase == HALF - 1) begin
                    pinClk <= ~pinClk;
                end
            end
        end
    end

    assign srcPins = {noise, pinClk};
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the timer with prescaler and postscaler
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    n_errors++; $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); \
    end end
module testbench;
    import tmsc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic [7:0] srcPins;
    logic sleepMode = 1'b0;
    logic timerOut;
    logic eventFlag;
    logic wakeReq;
    logic run = 1'b0;
    int n_errors = 0;
    int check_count = 0;

    always #4 sys_clk = ~sys_clk;

    tmsc_timer0 #(.PRESCALE_BITS(15)) u_dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .srcPins(srcPins), .sleepMode(sleepMode), .timerOut(timerOut),
        .eventFlag(eventFlag), .wakeReq(wakeReq));
    tmsc_src_model #(.HALF(4)) u_src (.sys_clk(sys_clk), .rst_n(rst_n),
        .run(run), .srcPins(srcPins));

    task automatic complete_run();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One-cycle strobes, changed just after the rising edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata; // Read data stand only in this cycle
    endtask

    // Cycles until timerOut changes; a hang ends the run
    task automatic wait_out(output int n);
        logic last;
        #1;
        last = timerOut;
        n = 0;
        while (timerOut === last) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 20000) begin
                n_errors++;
                complete_run();
            end
        end
    endtask

    task automatic period(output int p);
        wait_out(p); // First change only aligns the measurement
        wait_out(p);
    endtask

    task automatic wait_hi(input bit useWake, output int n);
        #1;
        n = 0;
        while ((useWake ? wakeReq : eventFlag) !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 5000) begin
                n_errors++;
                complete_run();
            end
        end
    endtask

    task automatic t_reset();
        logic [7:0] exp [5] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
        logic [7:0] d;
        `CHK({timerOut, eventFlag, wakeReq}, 3'h0)
        wr(4'h9, 8'h5A); // Unmapped write is dropped
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], d);
            `CHK(d, (a < 5) ? exp[a] : 8'h00)
        end
    endtask

    task automatic t_prescale();
        int p;
        wr(OFF_COUNT_HIGH, 8'h01);
        wr(OFF_CONFIG_FIRST, 8'h80);
        for (int n = 0; n < 11; n++) begin
            wr(OFF_CONFIG_SECOND, {SRC_SYS, 1'b0, n[3:0]});
            period(p);
            `CHK(p, 2 << n)
        end
    endtask

    task automatic t_postscale();
        int p;
        int divs [3] = '{0, 5, 15};
        wr(OFF_CONFIG_SECOND, 8'h40);
        foreach (divs[i]) begin
            wr(OFF_CONFIG_FIRST, 8'h80 | divs[i][7:0]);
            period(p);
            `CHK(p, 2 * (divs[i] + 1))
        end
    endtask

    // Scaler residue would bring the flag early
    task automatic t_clear();
        int n;
        wr(OFF_CONFIG_SECOND, 8'h43);
        wr(OFF_CONFIG_FIRST, 8'h81);
        for (int k = 0; k < 3; k++) begin
            repeat (5 + 7 * k) @(posedge sys_clk);
            wr(OFF_COUNT_LOW, 8'h00);
            wr(OFF_EVENT_STATUS, 8'h00);
            wait_hi(1'b0, n);
            // Low meets compare one advance after the clear, then every two
            `CHK(n + 2, 8 * 3 + 1)
        end
    endtask

    task automatic t_wide();
        int n;
        logic [7:0] d;
        wr(OFF_CONFIG_SECOND, 8'h40);
        wr(OFF_CONFIG_FIRST, 8'h90);
        wr(OFF_COUNT_HIGH, 8'hFF);
        wr(OFF_COUNT_LOW, 8'hF0);
        wr(OFF_EVENT_STATUS, 8'h00);
        wait_hi(1'b0, n);
        `CHK(n + 2, 16 + 1)
        rd(OFF_COUNT_HIGH, d);
        `CHK(d, 8'h00)
    endtask

    task automatic t_ext();
        int p;
        logic [7:0] a;
        logic [7:0] b;
        wr(OFF_CONFIG_SECOND, {SRC_EXT_RISE, 5'h00});
        wr(OFF_CONFIG_FIRST, 8'h80);
        wr(OFF_COUNT_HIGH, 8'h01);
        run <= 1'b1;
        period(p);
        `CHK(p, 16)
        run = 1'b0;
        rd(OFF_COUNT_LOW, a);
        repeat (40) @(posedge sys_clk);
        rd(OFF_COUNT_LOW, b);
        `CHK(b, a)
    endtask

    task automatic t_sleep();
        int n;
        logic [7:0] a;
        logic [7:0] b;
        wr(OFF_COUNT_HIGH, 8'h20);
        wr(OFF_CONFIG_SECOND, 8'h40);
        sleepMode <= 1'b1;
        rd(OFF_COUNT_LOW, a);
        repeat (20) @(posedge sys_clk);
        rd(OFF_COUNT_LOW, b);
        `CHK(b, a)
        run = 1'b1;
        wr(OFF_CONFIG_SECOND, 8'h10);
        wr(OFF_EVENT_STATUS, 8'h02);
        wait_hi(1'b1, n);
        `CHK({wakeReq, eventFlag}, 2'b11)
        wr(OFF_EVENT_STATUS, 8'h00);
        wait_hi(1'b0, n);
        `CHK(wakeReq, 1'b0)
        sleepMode <= 1'b0;
        run = 1'b0;
    endtask

    // Count bytes are never reloaded from an event handler
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_prescale();
        t_postscale();
        t_clear();
        t_wide();
        t_ext();
        t_sleep();
        complete_run();
    end
endmodule
